// ===== rtl/sto_interlock.sv
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - PWM patterns reach gate drivers only while output-stage enable is active.
// - Relay drive follows the trigger; withdrawing it cuts gate-driver supply.
// - Trigger and sensed supply compared constantly; lasting mismatch flags fault.
// - Driver-voltage fault suppressed whenever the relay trigger is off.
// - Feedback contact is normally closed, open only with supply present.
// - Entering torque-off de-energises the brake output, applying the brake.
// - In normal operation brake release follows the controller enable.
// - Output-stage enable low drives the brake off.
// - Trigger withdrawn switches the brake transistor off directly.
// - Torque-off shows a flashing indication on the display.
// - Feedback contact opens as soon as charged supply is sensed.
// - Indication cleared 10 ms after the feedback contact opens.
// - Controller enable rising edge starts brake release, enables stage internally.
// - Brake released only while the relay trigger is asserted.
// - Controller enable may come from a bus command, chosen by configuration.
// - Zero speed held for configurable delay after release; zero allowed.
// - On stop, after zero speed and drop-out delay, internal enable removed.
// - Feedback contact closes when discharged supply is sensed.
// - Indication returns 20 ms after feedback contact closes.
module sto_interlock
	import sto_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_output_stage_enable_in,
	input wire logic i_controller_enable_in,
	input wire logic i_relay_trigger,
	input wire logic i_driver_supply_ok,
	input wire logic i_zero_speed,
	input wire logic [5:0] i_pwm,
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic [5:0] o_pwm_gate,
	output logic o_relay_drive,
	output logic o_brake_hw_enable,
	output logic o_brake_release,
	output logic o_feedback_closed,
	output logic o_sto_display,
	output logic o_hold_zero_speed,
	output logic o_stage_enable_int,
	output logic o_pulse_fault,
	output logic o_driver_voltage_fault
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic stage_en;
	logic ctrl_en_pin;
	logic trig;
	logic supply;

	sto_sync u_sync_stage (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_pin(i_output_stage_enable_in), .o_level(stage_en));
	sto_sync u_sync_ctrl (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_pin(i_controller_enable_in), .o_level(ctrl_en_pin));
	sto_sync u_sync_trig (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_pin(i_relay_trigger), .o_level(trig));
	sto_sync u_sync_sup (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_pin(i_driver_supply_ok), .o_level(supply));

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	logic ack;
	logic [1:0] ctrl;
	logic [15:0] rel_dly;
	logic [15:0] drop_dly;
	logic pulse_fault;
	logic drv_fault;
	logic disp_on;
	sto_state_t state;
	wire req = (i_read || i_write) && !ack;
	wire wr_ctrl = i_write && ack && i_address == ADDR_CTRL;
	wire wr_rel = i_write && ack && i_address == ADDR_REL_DLY;
	wire wr_drop = i_write && ack && i_address == ADDR_DROP_DLY;
	wire clr_fault = wr_ctrl && i_writedata[CTRL_CLR_FAULT];
	wire [31:0] status_word = {20'h00000, ctrl_en_pin, stage_en, trig,
		supply, disp_on, drv_fault, pulse_fault, state};
	wire [31:0] rd_mux =
		(i_address == ADDR_CTRL) ? {30'h00000000, ctrl} :
		(i_address == ADDR_REL_DLY) ? {16'h0000, rel_dly} :
		(i_address == ADDR_DROP_DLY) ? {16'h0000, drop_dly} :
		(i_address == ADDR_STATUS) ? status_word : 32'h00000000;

	// One wait cycle, then the access completes
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ack <= 1'b0;
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h00000000;
		end else begin
			ack <= req;
			o_waitrequest <= !req;
			if (req && i_read) begin
				o_readdata <= rd_mux;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl <= CTRL_RESET;
			rel_dly <= REL_DLY_RESET;
			drop_dly <= DROP_DLY_RESET;
		end else begin
			if (wr_ctrl) ctrl <= i_writedata[1:0];
			if (wr_rel) rel_dly <= i_writedata[15:0];
			if (wr_drop) drop_dly <= i_writedata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Millisecond tick and display blink
	// ----------------------------------------------------------------
	logic [17:0] ms_cnt;
	logic ms_tick;
	logic [7:0] blink_cnt;
	logic blink;
	wire ms_wrap = ms_cnt == 18'(MS_CYCLES - 1);

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ms_cnt <= 18'h00000;
			ms_tick <= 1'b0;
		end else begin
			ms_cnt <= ms_wrap ? 18'h00000 : ms_cnt + 18'h00001;
			ms_tick <= ms_wrap;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			blink_cnt <= 8'h00;
			blink <= 1'b1;
		end else if (ms_tick) begin
			blink_cnt <= (blink_cnt == T_BLINK_MS - 8'h01) ? 8'h00 :
				blink_cnt + 8'h01;
			if (blink_cnt == T_BLINK_MS - 8'h01) blink <= !blink;
		end
	end

	// ----------------------------------------------------------------
	// Display indication timing
	// ----------------------------------------------------------------
	logic [7:0] disp_cnt;
	wire disp_flip_due = disp_on ? (supply && disp_cnt >= T_DISP_OFF_MS) :
		(!supply && disp_cnt >= T_DISP_ON_MS);
	wire disp_settled = disp_on ? !supply : supply;

	// Counts how long the supply differs from the shown indication
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			disp_cnt <= 8'h00;
			disp_on <= 1'b1;
		end else if (disp_settled || disp_flip_due) begin
			disp_cnt <= 8'h00;
			if (disp_flip_due) disp_on <= !disp_on;
		end else begin
			disp_cnt <= sto_ms_step(disp_cnt, ms_tick);
		end
	end

	// ----------------------------------------------------------------
	// Plausibility of trigger against sensed supply
	// ----------------------------------------------------------------
	logic [7:0] mis_cnt;
	wire mismatch = trig ^ supply;
	wire mis_expired = mis_cnt >= T_MISMATCH_MS;
	wire running = state inside {STO_RELEASE, STO_RUN, STO_STOPPING};
	wire drv_lost = trig && !supply && running;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mis_cnt <= 8'h00;
		end else begin
			mis_cnt <= mismatch ? sto_ms_step(mis_cnt, ms_tick) : 8'h00;
		end
	end

	// Sticky faults; a new event wins over a software clear
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pulse_fault <= 1'b0;
			drv_fault <= 1'b0;
		end else begin
			pulse_fault <= mis_expired || (pulse_fault && !clr_fault);
			drv_fault <= drv_lost || (drv_fault && !clr_fault);
		end
	end

	// ----------------------------------------------------------------
	// Enable sequencer
	// ----------------------------------------------------------------
	logic en_d;
	logic [15:0] dly_cnt;
	sto_state_t next_state;
	wire en_eff = ctrl[CTRL_BUS_SEL] ? ctrl[CTRL_BUS_EN] : ctrl_en_pin;
	wire en_rise = en_eff && !en_d;
	wire force_off = !trig || pulse_fault;
	wire rel_done = dly_cnt >= rel_dly;
	wire drop_done = i_zero_speed && dly_cnt >= drop_dly;

	always_comb begin
		next_state = state;
		unique case (state)
			STO_TORQUE_OFF: if (trig && !disp_on && !pulse_fault)
				next_state = STO_READY;
			STO_READY: if (en_rise && stage_en) next_state = STO_RELEASE;
			STO_RELEASE: if (!en_eff) next_state = STO_STOPPING;
				else if (rel_done) next_state = STO_RUN;
			STO_RUN: if (!en_eff) next_state = STO_STOPPING;
			STO_STOPPING: if (drop_done) next_state = STO_READY;
			default: next_state = STO_TORQUE_OFF;
		endcase
		if (force_off) next_state = STO_TORQUE_OFF;
		else if (!stage_en && running) next_state = STO_TORQUE_OFF;
	end

	// State register; reset lands in torque-off
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= STO_TORQUE_OFF;
			en_d <= 1'b0;
		end else begin
			state <= next_state;
			en_d <= en_eff;
		end
	end

	// Delay counter in ms, restarted on each state change
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dly_cnt <= 16'h0000;
		end else if (next_state != state) begin
			dly_cnt <= 16'h0000;
		end else if (state == STO_STOPPING && !i_zero_speed) begin
			dly_cnt <= 16'h0000;
		end else if (ms_tick && dly_cnt != 16'hFFFF) begin
			dly_cnt <= dly_cnt + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Output stage, brake, feedback and display drives
	// ----------------------------------------------------------------
	wire stage_int = next_state inside {STO_RELEASE, STO_RUN, STO_STOPPING};
	wire brake_ok = trig && stage_en && en_eff &&
		next_state inside {STO_RELEASE, STO_RUN};

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pwm_gate <= 6'h00;
			o_relay_drive <= 1'b0;
			o_brake_hw_enable <= 1'b0;
			o_brake_release <= 1'b0;
			o_feedback_closed <= 1'b1;
			o_sto_display <= 1'b0;
			o_hold_zero_speed <= 1'b0;
			o_stage_enable_int <= 1'b0;
			o_pulse_fault <= 1'b0;
			o_driver_voltage_fault <= 1'b0;
		end else begin
			o_pwm_gate <= (stage_en && stage_int) ? i_pwm : 6'h00;
			o_relay_drive <= trig;
			o_brake_hw_enable <= trig;
			o_brake_release <= brake_ok;
			o_feedback_closed <= !supply;
			o_sto_display <= disp_on && blink;
			o_hold_zero_speed <= next_state inside {STO_RELEASE, STO_STOPPING};
			o_stage_enable_int <= stage_int;
			o_pulse_fault <= pulse_fault;
			o_driver_voltage_fault <= drv_fault;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_rise_ready;
		state == STO_READY && en_rise && stage_en && !force_off;
	endsequence

	sequence s_release_on;
		state == STO_RELEASE ##1 o_stage_enable_int;
	endsequence

	a_pwm_blocked: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!stage_en |=> o_pwm_gate == 6'h00)
		else $error("PWM passed with stage enable low");
	a_relay_follow: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!trig |=> !o_relay_drive && !o_brake_hw_enable)
		else $error("Relay or brake transistor on without trigger");
	a_mismatch_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		mis_expired |=> pulse_fault ##1 state == STO_TORQUE_OFF)
		else $error("Lasting mismatch not flagged");
	a_no_drv_fault: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!trig && !drv_fault |=> !drv_fault)
		else $error("Driver fault raised with trigger off");
	a_feedback_nc: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		o_feedback_closed == !$past(supply))
		else $error("Feedback contact not inverse of supply");
	a_brake_sto: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state == STO_TORQUE_OFF |-> !o_brake_release)
		else $error("Brake released in torque-off");
	a_brake_trig: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		o_brake_release |-> $past(trig) && $past(stage_en))
		else $error("Brake released without trigger or stage enable");
	a_rise_starts: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		s_rise_ready |=> s_release_on)
		else $error("Enable edge did not start release");
	a_disp_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		disp_on && supply && disp_cnt >= T_DISP_OFF_MS |=> !disp_on)
		else $error("Indication not cleared after delay");
	a_drop_done: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		state == STO_STOPPING && drop_done && !force_off && stage_en
		|=> state == STO_READY ##1 !o_stage_enable_int)
		else $error("Internal enable not removed after drop-out");

endmodule : sto_interlock

// ===== rtl/sto_pkg.sv
package sto_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_MS_PS = 1000000000;
	localparam int CYC_PER_MS = T_MS_PS / CLK_PERIOD_PS;
	localparam logic [7:0] T_DISP_OFF_MS = 8'h0A;
	localparam logic [7:0] T_DISP_ON_MS = 8'h14;
	localparam logic [7:0] T_MISMATCH_MS = 8'h64;
	localparam logic [7:0] T_BLINK_MS = 8'hFA;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_REL_DLY = 4'h4;
	localparam logic [3:0] ADDR_DROP_DLY = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	localparam int CTRL_BUS_SEL = 0;
	localparam int CTRL_BUS_EN = 1;
	localparam int CTRL_CLR_FAULT = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [15:0] REL_DLY_RESET = 16'h0000;
	localparam logic [15:0] DROP_DLY_RESET = 16'h0000;
	localparam int ST_STATE = 0;
	localparam int ST_PULSE_FAULT = 5;
	localparam int ST_DRV_FAULT = 6;
	localparam int ST_DISPLAY = 7;
	localparam int ST_SUPPLY = 8;
	localparam int ST_TRIGGER = 9;
	localparam int ST_STAGE_EN = 10;
	localparam int ST_CTRL_EN = 11;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		STO_TORQUE_OFF = 5'b00001,
		STO_READY = 5'b00010,
		STO_RELEASE = 5'b00100,
		STO_RUN = 5'b01000,
		STO_STOPPING = 5'b10000
	} sto_state_t;

	// Saturating millisecond counter step
	function automatic logic [7:0] sto_ms_step(input logic [7:0] c,
		input logic tick);
		sto_ms_step = (tick && c != 8'hFF) ? c + 8'h01 : c;
	endfunction : sto_ms_step

endpackage : sto_pkg

// ===== rtl/sto_sync.sv
`timescale 1ns/1ps

// Three-stage pin synchroniser; output moves once stages two and three agree
module sto_sync (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_pin,
	output logic o_level
);
	logic ff1;
	logic ff2;
	logic ff3;

	// ----------------------------------------------------------------
	// Sampling chain
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ff1 <= 1'b0;
			ff2 <= 1'b0;
			ff3 <= 1'b0;
			o_level <= 1'b0;
		end else begin
			ff1 <= i_pin;
			ff2 <= ff1;
			ff3 <= ff2;
			if (ff2 == ff3) begin
				o_level <= ff3;
			end
		end
	end

endmodule : sto_sync

// ===== verification/safe_torque_off_interlock_tb_top.sv
`timescale 1ns/1ps

`define CHK(n, e, a) \
	begin \
		checks++; \
		if ((a) !== (e)) begin \
			$display("unexpected %s exp %0h got %0h", n, e, a); \
			err_total++; \
		end \
	end

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module safe_torque_off_interlock_tb_top;
	import sto_pkg::*;
	localparam int MS = 20;
	localparam logic [31:0] S_OFF = (32'h1 << ST_DISPLAY) | 32'h01;
	localparam logic [31:0] S_RDY = (32'h1 << ST_SUPPLY) |
		(32'h1 << ST_TRIGGER) | (32'h1 << ST_STAGE_EN) | 32'h02;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic c_trig = 1'b0;
	logic c_stage = 1'b0;
	logic c_en = 1'b0;
	logic c_brk = 1'b0;
	logic stg, cen, trg, sup, mism;
	logic i_zero_speed = 1'b0;
	logic [5:0] i_pwm = 6'h00;
	logic [3:0] i_address = 4'h0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h00000000;
	logic [31:0] o_readdata;
	logic [5:0] o_pwm_gate;
	logic o_waitrequest, o_relay_drive, o_brake_hw_enable, o_brake_release;
	logic o_feedback_closed, o_sto_display, o_hold_zero_speed;
	logic o_stage_enable_int, o_pulse_fault, o_driver_voltage_fault;
	int err_total = 0;
	int checks = 0;
	logic [31:0] lfsr = 32'h00001829;
	logic [31:0] exp_q[$];
	logic [31:0] rd_exp;

	// Clock
	always #2 i_core_clk = ~i_core_clk;

	sto_interlock #(.MS_CYCLES(MS)) u_dut (.i_core_clk(i_core_clk),
		.i_resetn(i_resetn), .i_output_stage_enable_in(stg),
		.i_controller_enable_in(cen), .i_relay_trigger(trg),
		.i_driver_supply_ok(sup), .i_zero_speed(i_zero_speed),
		.i_pwm(i_pwm), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.o_pwm_gate(o_pwm_gate), .o_relay_drive(o_relay_drive),
		.o_brake_hw_enable(o_brake_hw_enable),
		.o_brake_release(o_brake_release),
		.o_feedback_closed(o_feedback_closed),
		.o_sto_display(o_sto_display),
		.o_hold_zero_speed(o_hold_zero_speed),
		.o_stage_enable_int(o_stage_enable_int),
		.o_pulse_fault(o_pulse_fault),
		.o_driver_voltage_fault(o_driver_voltage_fault));

	sto_ctl_model u_ctl (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_cmd_trigger(c_trig), .i_cmd_stage(c_stage), .i_cmd_enable(c_en),
		.i_break_supply(c_brk), .i_relay_drive(o_relay_drive),
		.i_feedback_closed(o_feedback_closed), .o_relay_trigger(trg),
		.o_stage_en(stg), .o_ctrl_en(cen), .o_supply_ok(sup),
		.o_mismatch(mism));

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	task automatic tally_and_finish();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : cyc

	// Avalon cycle; a read notes its expected word
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		if (!wr)
			exp_q.push_back(d);
		i_address <= a;
		i_write <= wr;
		i_read <= !wr;
		i_writedata <= wr ? d : 32'h00000000;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		i_read <= 1'b0;
		i_write <= 1'b0;
		if (n >= 50) begin
			err_total++;
			tally_and_finish();
		end
		@(posedge i_core_clk);
	endtask : bus

	// Random patterns against the gated drive
	task automatic pwm_chk(input logic pass);
		logic [5:0] r;
		repeat (8) begin
			lfsr = lfsr_next(lfsr);
			r = lfsr[5:0];
			i_pwm <= r;
			cyc(2);
			`CHK("pwm_gate", pass ? r : 6'h00, o_pwm_gate)
		end
	endtask : pwm_chk

	task automatic wait_fb(input logic lvl, input int lim);
		int n;
		n = 0;
		while (o_feedback_closed !== lvl && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			err_total++;
			tally_and_finish();
		end
	endtask : wait_fb

	// Takes the oldest note whenever read data is answered
	always @(posedge i_core_clk) begin
		if (i_read && o_waitrequest === 1'b0) begin
			rd_exp = exp_q.pop_front();
			`CHK("readdata", rd_exp, o_readdata)
		end
	end

	// Hang guard
	initial begin
		cyc(100000);
		err_total++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		cyc(6);
		`CHK("waitreq", 1'b1, o_waitrequest)
		`CHK("fb_rst", 1'b1, o_feedback_closed)
		`CHK("brake_rst", 1'b0, o_brake_release)
		`CHK("stage_rst", 1'b0, o_stage_enable_int)
		i_resetn <= 1'b1;
		cyc(2);
		bus(0, ADDR_STATUS, S_OFF);
		bus(0, ADDR_CTRL, 32'h00000000);
		bus(0, ADDR_REL_DLY, 32'h00000000);
		bus(0, ADDR_DROP_DLY, 32'h00000000);
		bus(1, 4'h2, 32'h00000005);
		bus(0, 4'h2, 32'h00000000);
		bus(1, ADDR_REL_DLY, 32'hFFFF0003);
		bus(0, ADDR_REL_DLY, 32'h00000003);
		bus(1, ADDR_DROP_DLY, 32'h00000002);
		bus(0, ADDR_DROP_DLY, 32'h00000002);
		bus(1, ADDR_CTRL, 32'h00000004);
		bus(0, ADDR_CTRL, 32'h00000000);
		`CHK("display", 1'b1, o_sto_display)
		`CHK("drv_fault", 1'b0, o_driver_voltage_fault)
		`CHK("relay", 1'b0, o_relay_drive)
		`CHK("brake_hw", 1'b0, o_brake_hw_enable)
		pwm_chk(1'b0);
		c_trig <= 1'b1;
		cyc(8);
		`CHK("relay", 1'b1, o_relay_drive)
		`CHK("brake_hw", 1'b1, o_brake_hw_enable)
		wait_fb(1'b0, 20 * MS);
		`CHK("fb_open", 1'b0, o_feedback_closed)
		cyc(8 * MS);
		`CHK("display", 1'b1, o_sto_display)
		cyc(4 * MS);
		`CHK("display", 1'b0, o_sto_display)
		c_stage <= 1'b1;
		cyc(2600);
		bus(0, ADDR_STATUS, S_RDY);
		c_en <= 1'b1;
		cyc(12);
		`CHK("stage_int", 1'b1, o_stage_enable_int)
		`CHK("brake", 1'b1, o_brake_release)
		`CHK("hold", 1'b1, o_hold_zero_speed)
		cyc(MS);
		`CHK("hold", 1'b1, o_hold_zero_speed)
		cyc(4 * MS);
		`CHK("hold", 1'b0, o_hold_zero_speed)
		pwm_chk(1'b1);
		i_zero_speed <= 1'b1;
		c_en <= 1'b0;
		cyc(12);
		`CHK("brake", 1'b0, o_brake_release)
		`CHK("stage_int", 1'b1, o_stage_enable_int)
		cyc(5 * MS);
		`CHK("stage_int", 1'b0, o_stage_enable_int)
		bus(0, ADDR_STATUS, S_RDY);
		bus(1, ADDR_REL_DLY, 32'h00000000);
		bus(1, ADDR_CTRL, 32'h00000001);
		bus(1, ADDR_CTRL, 32'h00000003);
		cyc(6);
		`CHK("brake", 1'b1, o_brake_release)
		cyc(2 * MS);
		`CHK("hold", 1'b0, o_hold_zero_speed)
		c_stage <= 1'b0;
		cyc(10);
		`CHK("brake", 1'b0, o_brake_release)
		`CHK("stage_int", 1'b0, o_stage_enable_int)
		pwm_chk(1'b0);
		bus(1, ADDR_CTRL, 32'h00000000);
		c_trig <= 1'b0;
		cyc(8);
		`CHK("relay", 1'b0, o_relay_drive)
		`CHK("brake_hw", 1'b0, o_brake_hw_enable)
		wait_fb(1'b1, 100 * MS);
		`CHK("fb_close", 1'b1, o_feedback_closed)
		cyc(32 * MS);
		bus(0, ADDR_STATUS, S_OFF);
		c_brk <= 1'b1;
		c_trig <= 1'b1;
		cyc(90 * MS);
		`CHK("pulse_fault", 1'b0, o_pulse_fault)
		cyc(20 * MS);
		`CHK("pulse_fault", 1'b1, o_pulse_fault)
		`CHK("drv_fault", 1'b0, o_driver_voltage_fault)
		c_trig <= 1'b0;
		c_brk <= 1'b0;
		cyc(10);
		bus(1, ADDR_CTRL, 32'h00000004);
		cyc(2);
		`CHK("pulse_fault", 1'b0, o_pulse_fault)
		`CHK("ctl_mism", 1'b0, mism)
		tally_and_finish();
	end
endmodule : safe_torque_off_interlock_tb_top

// ===== verification/sto_ctl_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Safety controller and driver supply model
// ----------------------------------------------------------------
module sto_ctl_model #(
	parameter int T_CHARGE = 200,
	parameter int T_DISCH = 1600,
	parameter int T_PLAUS = 2400
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_cmd_trigger,
	input wire logic i_cmd_stage,
	input wire logic i_cmd_enable,
	input wire logic i_break_supply,
	input wire logic i_relay_drive,
	input wire logic i_feedback_closed,
	output logic o_relay_trigger = 1'b0,
	output logic o_stage_en = 1'b0,
	output logic o_ctrl_en = 1'b0,
	output logic o_supply_ok = 1'b0,
	output logic o_mismatch = 1'b0
);
	int ct = 0;
	int bad = 0;
	logic want;
	assign want = i_relay_drive && !i_break_supply;

	// Supply follows the relay after charge or discharge time
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ct <= 0;
			o_supply_ok <= 1'b0;
		end else if (want == o_supply_ok) begin
			ct <= 0;
		end else if (ct >= (o_supply_ok ? T_DISCH : T_CHARGE)) begin
			ct <= 0;
			o_supply_ok <= want;
		end else begin
			ct <= ct + 1;
		end
	end

	// Pins and the plausibility watch on the feedback contact
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bad <= 0;
			o_mismatch <= 1'b0;
			o_relay_trigger <= 1'b0;
			o_stage_en <= 1'b0;
			o_ctrl_en <= 1'b0;
		end else begin
			bad <= (i_feedback_closed == o_relay_trigger) ? bad + 1 : 0;
			if (bad >= T_PLAUS)
				o_mismatch <= 1'b1;
			o_relay_trigger <= i_cmd_trigger;
			o_stage_en <= i_cmd_stage && !o_mismatch;
			o_ctrl_en <= i_cmd_enable && !o_mismatch;
		end
	end
endmodule : sto_ctl_model
